// file: logic/addr_entry_ram.sv
// Receive address RAM with one write port and a registered read port.
`timescale 1ns/100ps
module addr_entry_ram
    import emac_addr_pkg::*;
#(
    parameter int DEPTH = RAM_DEPTH,
    parameter int WIDTH = ENTRY_W
) (
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Entries have no reset; software must program all of them before use.
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : addr_entry_ram

// file: logic/chan_pointer_bank.sv
// Head and completion pointers for eight DMA channels, with start, error and interrupt.
`timescale 1ns/100ps
module chan_pointer_bank
    import emac_addr_pkg::*;
#(
    parameter int NCH = CHANNELS
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic head_we,
    input wire logic cp_we,
    input wire logic [CHAN_W-1:0] wr_chan,
    input wire logic [31:0] wdata,
    input wire logic done_valid,
    input wire logic [CHAN_W-1:0] done_chan,
    input wire logic [31:0] done_ptr,
    input wire logic done_eoq,
    output logic [NCH-1:0][31:0] head_ptr,
    output logic [NCH-1:0][31:0] comp_ptr,
    output logic [NCH-1:0] start,
    output logic [NCH-1:0] busy,
    output logic [NCH-1:0] chan_irq,
    output logic write_error,
    output logic done_event
);
    logic [NCH-1:0][31:0] last;
    logic [NCH-1:0] pend;

    // Channel decode of each request.
    wire head_busy = (head_ptr[wr_chan] != 32'h0);
    wire accept_head = head_we && !head_busy;
    wire [NCH-1:0] one_hot_wr = NCH'(1) << wr_chan;
    wire [NCH-1:0] one_hot_done = NCH'(1) << done_chan;
    wire [NCH-1:0] head_sel = accept_head ? one_hot_wr : '0;
    wire [NCH-1:0] cp_sel = cp_we ? one_hot_wr : '0;
    wire [NCH-1:0] done_sel = done_valid ? one_hot_done : '0;

    // A write over a live queue is refused so the running chain is not lost.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            head_ptr <= '0;
            comp_ptr <= '0;
            last <= '0;
            pend <= '0;
            start <= '0;
            write_error <= 1'b0;
            done_event <= 1'b0;
        end else begin
            write_error <= head_we && head_busy;
            done_event <= done_valid;
            for (int c = 0; c < NCH; c++) begin
                start[c] <= head_sel[c] && (wdata != 32'h0);
                if (head_sel[c]) begin
                    head_ptr[c] <= wdata;
                end else if (done_sel[c] && done_eoq) begin
                    head_ptr[c] <= 32'h0;
                end
                if (cp_sel[c]) begin
                    comp_ptr[c] <= wdata;
                end
                if (done_sel[c]) begin
                    last[c] <= done_ptr;
                    pend[c] <= 1'b1;
                end else if (cp_sel[c] && (wdata == last[c])) begin
                    pend[c] <= 1'b0;
                end
            end
        end
    end

    // Queue state seen by the DMA engine.
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            busy[c] = (head_ptr[c] != 32'h0);
        end
    end
    assign chan_irq = pend;

    property p_start_on_head;
        @(posedge clk_sys) disable iff (!rst_b)
        head_we && !head_busy && (wdata != 32'h0) |=> start[$past(wr_chan)];
    endproperty
    a_start_on_head: assert property (p_start_on_head) else $error("no start pulse");
    property p_head_error;
        @(posedge clk_sys) disable iff (!rst_b)
        head_we && head_busy && !(done_valid && done_chan == wr_chan) |=>
            write_error && head_ptr[$past(wr_chan)] == $past(head_ptr[wr_chan]);
    endproperty
    a_head_error: assert property (p_head_error) else $error("busy head not flagged");
    property p_irq_clear;
        @(posedge clk_sys) disable iff (!rst_b)
        cp_we && (wdata == last[wr_chan]) && !done_valid |=> !chan_irq[$past(wr_chan)];
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq kept after ack");
    property p_irq_hold;
        @(posedge clk_sys) disable iff (!rst_b)
        chan_irq[0] && !cp_we |=> chan_irq[0];
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped unacked");
endmodule : chan_pointer_bank

// file: logic/emac_addr_pkg.sv
// Shared register map, field layout and reset values for the address RAM and DMA pointer block.
package emac_addr_pkg;
    // Register byte offsets.
    localparam int ADDR_W = 9;
    localparam logic [8:0] OFS_LOWER = 9'h000;
    localparam logic [8:0] OFS_UPPER = 9'h004;
    localparam logic [8:0] OFS_INDEX = 9'h008;
    localparam logic [8:0] OFS_STATUS = 9'h00c;
    localparam logic [8:0] OFS_MASK = 9'h010;
    localparam logic [8:0] OFS_CHAN = 9'h014;
    localparam logic [8:0] OFS_TX_HEAD = 9'h100;
    localparam logic [8:0] OFS_RX_HEAD = 9'h120;
    localparam logic [8:0] OFS_TX_CP = 9'h140;
    localparam logic [8:0] OFS_RX_CP = 9'h160;
    // Low address register fields.
    localparam int VALID_BIT = 20;
    localparam int MATCH_BIT = 19;
    localparam int CHAN_LSB = 16;
    localparam int CHAN_W = 3;
    localparam int LOWER_W = 21;
    // Address RAM geometry and entry layout.
    localparam int INDEX_W = 5;
    localparam int RAM_DEPTH = 32;
    localparam int ENTRY_W = 53;
    localparam int E_VALID = 52;
    localparam int E_MATCH = 51;
    localparam int E_CHAN_LSB = 48;
    localparam int CHANNELS = 8;
    // Interrupt status bits.
    localparam int ST_TX_ERR = 0;
    localparam int ST_RX_ERR = 1;
    localparam int ST_TX_DONE = 2;
    localparam int ST_RX_DONE = 3;
    localparam int ST_W = 4;
    // Reset values.
    localparam logic [4:0] RST_INDEX = 5'h00;
    localparam logic [3:0] RST_MASK = 4'h0;

    // True when a byte address falls in the eight-word bank at base.
    function automatic logic bank_hit(input logic [8:0] addr, input logic [8:0] base);
        bank_hit = (addr[8:5] == base[8:5]);
    endfunction : bank_hit
endpackage : emac_addr_pkg

// file: logic/mac_address_ram_and_dma_pointers.sv
// Register front end: receive address RAM loading, lookup and DMA pointer banks.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module mac_address_ram_and_dma_pointers
    import emac_addr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic tx_done_valid,
    input wire logic [CHAN_W-1:0] tx_done_chan,
    input wire logic [31:0] tx_done_ptr,
    input wire logic tx_done_eoq,
    input wire logic rx_done_valid,
    input wire logic [CHAN_W-1:0] rx_done_chan,
    input wire logic [31:0] rx_done_ptr,
    input wire logic rx_done_eoq,
    output logic [CHANNELS-1:0][31:0] tx_head_ptr,
    output logic [CHANNELS-1:0][31:0] rx_head_ptr,
    output logic [CHANNELS-1:0] tx_start,
    output logic [CHANNELS-1:0] tx_busy,
    output logic [CHANNELS-1:0] rx_armed,
    output logic [CHANNELS-1:0] tx_chan_irq,
    output logic [CHANNELS-1:0] rx_chan_irq,
    input wire logic lookup_req,
    input wire logic [INDEX_W-1:0] lookup_index,
    input wire logic [47:0] lookup_addr,
    output logic lookup_done,
    output logic lookup_hit,
    output logic lookup_reject,
    output logic [CHAN_W-1:0] lookup_channel,
    output logic rx_store
);
    ////////////////////////////////////////////////////////////////////////////////
    // Register decode.

    logic [31:0] upper;
    logic [LOWER_W-1:0] lower;
    logic [INDEX_W-1:0] index;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [CHANNELS-1:0][31:0] tx_cp;
    logic [CHANNELS-1:0][31:0] rx_cp;
    logic [CHANNELS-1:0] rx_start;
    logic tx_err;
    logic rx_err;
    logic tx_ev;
    logic rx_ev;

    // Address decode of the plain register port.
    wire sel_lower = (reg_addr == OFS_LOWER);
    wire sel_upper = (reg_addr == OFS_UPPER);
    wire sel_index = (reg_addr == OFS_INDEX);
    wire sel_status = (reg_addr == OFS_STATUS);
    wire sel_mask = (reg_addr == OFS_MASK);
    wire sel_chan = (reg_addr == OFS_CHAN);
    wire sel_tx_head = bank_hit(reg_addr, OFS_TX_HEAD);
    wire sel_rx_head = bank_hit(reg_addr, OFS_RX_HEAD);
    wire sel_tx_cp = bank_hit(reg_addr, OFS_TX_CP);
    wire sel_rx_cp = bank_hit(reg_addr, OFS_RX_CP);
    wire [CHAN_W-1:0] reg_chan = reg_addr[4:2];

    ////////////////////////////////////////////////////////////////////////////////
    // Address staging and index registers.

    // Staging registers only; the entry itself is written by the lower-word write.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            upper <= 32'h0;
            lower <= '0;
            index <= RST_INDEX;
        end else if (reg_wr) begin
            if (sel_upper) begin
                upper <= reg_wdata;
            end
            if (sel_lower) begin
                lower <= reg_wdata[LOWER_W-1:0];
            end
            if (sel_index) begin
                index <= reg_wdata[INDEX_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address RAM commit and lookup.

    logic [ENTRY_W-1:0] ent;
    logic [47:0] addr_q;
    logic req_q;
    logic [CHANNELS-1:0] armed_q;

    // Entry layout: valid, match, channel, then the address with byte 5 on top.
    wire ram_we = reg_wr && sel_lower;
    wire [47:0] new_mac = {upper[7:0], upper[15:8], upper[23:16], upper[31:24],
                           reg_wdata[7:0], reg_wdata[15:8]};
    wire [ENTRY_W-1:0] ram_wdata = {reg_wdata[VALID_BIT], reg_wdata[MATCH_BIT],
                                    reg_wdata[CHAN_LSB+CHAN_W-1:CHAN_LSB], new_mac};

    addr_entry_ram #(
        .DEPTH(RAM_DEPTH),
        .WIDTH(ENTRY_W)
    ) u_ram (
        .clk_sys(clk_sys),
        .we(ram_we),
        .waddr(index),
        .wdata(ram_wdata),
        .raddr(lookup_index),
        .rdata(ent)
    );

    // Decision from the entry read one cycle after the request.
    wire ent_valid = ent[E_VALID];
    wire ent_match = ent[E_MATCH];
    wire [CHAN_W-1:0] ent_chan = ent[E_CHAN_LSB+CHAN_W-1:E_CHAN_LSB];
    wire addr_eq = (ent[47:0] == addr_q);
    wire next_hit = req_q && ent_valid && ent_match && addr_eq;
    wire next_reject = req_q && ent_valid && !ent_match && addr_eq;
    wire next_store = next_hit && rx_armed[ent_chan];

    // Results are registered so the filter sees clean levels two cycles after asking.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            req_q <= 1'b0;
            addr_q <= 48'h0;
            lookup_done <= 1'b0;
            lookup_hit <= 1'b0;
            lookup_reject <= 1'b0;
            lookup_channel <= '0;
            rx_store <= 1'b0;
            armed_q <= '0;
        end else begin
            req_q <= lookup_req;
            addr_q <= lookup_addr;
            lookup_done <= req_q;
            lookup_hit <= next_hit;
            lookup_reject <= next_reject;
            lookup_channel <= next_hit ? ent_chan : '0;
            rx_store <= next_store;
            armed_q <= rx_armed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // DMA pointer banks.

    chan_pointer_bank #(
        .NCH(CHANNELS)
    ) u_tx (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .head_we(reg_wr && sel_tx_head),
        .cp_we(reg_wr && sel_tx_cp),
        .wr_chan(reg_chan),
        .wdata(reg_wdata),
        .done_valid(tx_done_valid),
        .done_chan(tx_done_chan),
        .done_ptr(tx_done_ptr),
        .done_eoq(tx_done_eoq),
        .head_ptr(tx_head_ptr),
        .comp_ptr(tx_cp),
        .start(tx_start),
        .busy(tx_busy),
        .chan_irq(tx_chan_irq),
        .write_error(tx_err),
        .done_event(tx_ev)
    );

    chan_pointer_bank #(
        .NCH(CHANNELS)
    ) u_rx (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .head_we(reg_wr && sel_rx_head),
        .cp_we(reg_wr && sel_rx_cp),
        .wr_chan(reg_chan),
        .wdata(reg_wdata),
        .done_valid(rx_done_valid),
        .done_chan(rx_done_chan),
        .done_ptr(rx_done_ptr),
        .done_eoq(rx_done_eoq),
        .head_ptr(rx_head_ptr),
        .comp_ptr(rx_cp),
        .start(rx_start),
        .busy(rx_armed),
        .chan_irq(rx_chan_irq),
        .write_error(rx_err),
        .done_event(rx_ev)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask.

    // A new event in the same cycle as the clearing read survives the clear.
    wire [ST_W-1:0] st_set = {rx_ev, tx_ev, rx_err, tx_err};
    wire [ST_W-1:0] st_clr = (reg_rd && sel_status) ? {ST_W{1'b1}} : '0;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            status <= '0;
            mask <= RST_MASK;
        end else begin
            status <= (status & ~st_clr) | st_set;
            if (reg_wr && sel_mask) begin
                mask <= reg_wdata[ST_W-1:0];
            end
        end
    end
    assign irq = |(status & mask);

    ////////////////////////////////////////////////////////////////////////////////
    // Read data.

    // Unmapped offsets and reserved bits read as zero.
    wire [31:0] rd_lower = {11'h0, lower};
    wire [31:0] rd_index = {27'h0, index};
    wire [31:0] rd_chan = {rx_chan_irq, tx_chan_irq, rx_armed, tx_busy};
    wire [31:0] next_rdata =
        sel_lower ? rd_lower :
        sel_upper ? upper :
        sel_index ? rd_index :
        sel_status ? {28'h0, status} :
        sel_mask ? {28'h0, mask} :
        sel_chan ? rd_chan :
        sel_tx_head ? tx_head_ptr[reg_chan] :
        sel_rx_head ? rx_head_ptr[reg_chan] :
        sel_tx_cp ? tx_cp[reg_chan] :
        sel_rx_cp ? rx_cp[reg_chan] : 32'h0;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_upper_back;
        @(posedge clk_sys) disable iff (!rst_b)
        (reg_wr && sel_upper) ##1 !reg_wr ##1 (reg_rd && sel_upper) |=>
            reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_upper_back: assert property (p_upper_back) else $error("upper readback wrong");
    property p_index_write;
        @(posedge clk_sys) disable iff (!rst_b)
        reg_wr && sel_index |=> index == $past(reg_wdata[INDEX_W-1:0]);
    endproperty
    a_index_write: assert property (p_index_write) else $error("index not stored");
    property p_index_read;
        @(posedge clk_sys) disable iff (!rst_b)
        reg_rd && sel_index |=> reg_rdata[31:5] == 27'h0 && reg_rdata[4:0] == $past(index);
    endproperty
    a_index_read: assert property (p_index_read) else $error("index read wrong");
    // The entry must survive an upper write, or a half-loaded address could match frames.
    property p_commit_low;
        @(posedge clk_sys) disable iff (!rst_b)
        reg_wr && sel_upper |=> u_ram.mem[$past(index)] == $past(u_ram.mem[index]);
    endproperty
    a_commit_low: assert property (p_commit_low) else $error("entry written off low");
    property p_commit_lands;
        @(posedge clk_sys) disable iff (!rst_b)
        ram_we |=> u_ram.mem[$past(index)] == $past(ram_wdata);
    endproperty
    a_commit_lands: assert property (p_commit_lands) else $error("entry not written");
    property p_lower_back;
        @(posedge clk_sys) disable iff (!rst_b)
        (reg_wr && sel_lower) ##1 !reg_wr ##1 (reg_rd && sel_lower) |=>
            reg_rdata == {11'h0, $past(reg_wdata[LOWER_W-1:0], 3)};
    endproperty
    a_lower_back: assert property (p_lower_back) else $error("lower readback wrong");
    property p_valid_needed;
        @(posedge clk_sys) disable iff (!rst_b)
        lookup_hit || lookup_reject |-> $past(ent_valid) && $past(req_q);
    endproperty
    a_valid_needed: assert property (p_valid_needed) else $error("invalid entry used");
    property p_match_select;
        @(posedge clk_sys) disable iff (!rst_b)
        lookup_hit |-> $past(ent_match) && lookup_channel == $past(ent_chan) && !lookup_reject;
    endproperty
    a_match_select: assert property (p_match_select) else $error("match select wrong");
    property p_store_armed;
        @(posedge clk_sys) disable iff (!rst_b)
        rx_store |-> lookup_hit && armed_q[lookup_channel];
    endproperty
    a_store_armed: assert property (p_store_armed) else $error("store on idle channel");
    property p_arm_enables;
        @(posedge clk_sys) disable iff (!rst_b)
        lookup_hit && armed_q[lookup_channel] |-> rx_store;
    endproperty
    a_arm_enables: assert property (p_arm_enables) else $error("armed hit not stored");
    // A read with no event pending must leave every sticky bit clear.
    property p_status_clear;
        @(posedge clk_sys) disable iff (!rst_b)
        reg_rd && sel_status && st_set == '0 |=> status == '0;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status not cleared");
    // Read data must not linger, or a later poll would see a stale word.
    property p_rdata_idle;
        @(posedge clk_sys) disable iff (!rst_b)
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingers");

    c_entry_load: cover property (@(posedge clk_sys) disable iff (!rst_b)
        (reg_wr && sel_index) ##1 (reg_wr && sel_upper) ##1 (reg_wr && sel_lower));
    c_stored: cover property (@(posedge clk_sys) disable iff (!rst_b) rx_store);
    c_reject: cover property (@(posedge clk_sys) disable iff (!rst_b) lookup_reject);
    c_tx_start: cover property (@(posedge clk_sys) disable iff (!rst_b) |tx_start);
    c_rx_arm: cover property (@(posedge clk_sys) disable iff (!rst_b) |rx_start);
endmodule : mac_address_ram_and_dma_pointers

// file: verification/dma_engine_model.sv
// Behavioural DMA engine that finishes started descriptor queues for the register block.
`timescale 1ns/100ps
module dma_engine_model
    import emac_addr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hold,
    input wire logic [CHANNELS-1:0] tx_start,
    input wire logic [CHANNELS-1:0][31:0] tx_head_ptr,
    input wire logic [CHANNELS-1:0][31:0] rx_head_ptr,
    input wire logic rx_store,
    input wire logic [CHAN_W-1:0] lookup_channel,
    output logic tx_done_valid,
    output logic [CHAN_W-1:0] tx_done_chan,
    output logic [31:0] tx_done_ptr,
    output logic tx_done_eoq,
    output logic rx_done_valid,
    output logic [CHAN_W-1:0] rx_done_chan,
    output logic [31:0] rx_done_ptr,
    output logic rx_done_eoq
);
    logic [CHANNELS-1:0] pend;
    logic [CHANNELS-1:0] pend_all;
    logic [CHAN_W-1:0] pick;

    ////////////////////////////////////////////////////////////////////////////////
    // Lowest started channel is served first; hold keeps TX heads nonzero for error cases.
    assign pend_all = pend | tx_start;
    always_comb begin
        pick = '0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (pend_all[i]) pick = CHAN_W'(i);
        end
    end

    // Idle qualifiers flip every cycle so a stale value can never pass for a fresh one.
    always_ff @(posedge clk_sys) begin
        tx_done_valid <= 1'b0;
        rx_done_valid <= 1'b0;
        tx_done_chan <= ~tx_done_chan;
        tx_done_ptr <= ~tx_done_ptr;
        tx_done_eoq <= ~tx_done_eoq;
        rx_done_chan <= ~rx_done_chan;
        rx_done_ptr <= ~rx_done_ptr;
        rx_done_eoq <= ~rx_done_eoq;
        pend <= pend_all;
        if (!rst_b) begin
            pend <= '0;
            tx_done_chan <= '0;
            tx_done_ptr <= '0;
            tx_done_eoq <= 1'b0;
            rx_done_chan <= '0;
            rx_done_ptr <= '0;
            rx_done_eoq <= 1'b0;
        end else begin
            if (!hold && pend_all != '0) begin
                tx_done_valid <= 1'b1;
                tx_done_chan <= pick;
                tx_done_ptr <= tx_head_ptr[pick];
                tx_done_eoq <= 1'b1;
                pend[pick] <= 1'b0;
            end
            if (rx_store) begin
                rx_done_valid <= 1'b1;
                rx_done_chan <= lookup_channel;
                rx_done_ptr <= rx_head_ptr[lookup_channel];
                rx_done_eoq <= 1'b1;
            end
        end
    end
endmodule : dma_engine_model

// file: verification/mac_address_ram_and_dma_pointers_tb.sv
// Self-checking bench for the address RAM and DMA pointer register block.
`timescale 1ns/100ps
module mac_address_ram_and_dma_pointers_tb
    import emac_addr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic hold = 1'b0;
    logic lookup_req = 1'b0;
    logic [INDEX_W-1:0] lookup_index = '0;
    logic [47:0] lookup_addr = '0;
    logic [31:0] reg_rdata, tx_done_ptr, rx_done_ptr;
    logic irq, tx_done_valid, tx_done_eoq, rx_done_valid, rx_done_eoq;
    logic [CHAN_W-1:0] tx_done_chan, rx_done_chan, lookup_channel;
    logic [CHANNELS-1:0][31:0] tx_head_ptr, rx_head_ptr;
    logic [CHANNELS-1:0] tx_start, tx_busy, rx_armed, tx_chan_irq, rx_chan_irq;
    logic lookup_done, lookup_hit, lookup_reject, rx_store;
    int miscompares = 0;
    int comparisons = 0;

    mac_address_ram_and_dma_pointers i_mac_address_ram_and_dma_pointers (.*);
    dma_engine_model i_dma_engine_model (.*);

    ////////////////////////////////////////////////////////////////////////////////
    // A 100 ns clock.
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [8:0] at(input logic [8:0] base, input int n);
        at = base + 9'(4 * n);
    endfunction : at

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cycles

    // Bus cycles return just after the taking edge, so the next call starts one edge later.
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask : rd

    task automatic prog(input logic [4:0] idx, input logic [31:0] up, input logic [31:0] lo);
        wr(OFS_INDEX, {27'h0, idx});
        wr(OFS_UPPER, up);
        wr(OFS_LOWER, lo);
    endtask : prog

    // Expected result packs done, hit, reject, channel and store from the top bit down.
    task automatic look(input logic [4:0] idx, input logic [47:0] a, input logic [6:0] exp);
        @(posedge clk_sys);
        lookup_req <= 1'b1;
        lookup_index <= idx;
        lookup_addr <= a;
        @(posedge clk_sys);
        lookup_req <= 1'b0;
        cycles(1);
        chk("lookup", {25'h0, lookup_done, lookup_hit, lookup_reject, lookup_channel, rx_store},
            {25'h0, exp});
    endtask : look

    // A missing completion would hang the run, so the wait is bounded.
    task automatic tx_done(input int ch, input logic [31:0] ptr);
        for (int k = 0; k < 20 && tx_chan_irq[ch] !== 1'b1; k++) cycles(1);
        if (tx_chan_irq[ch] !== 1'b1) begin
            miscompares++;
            close_out();
        end else begin
            chk("tx_irq", {24'h0, tx_chan_irq}, 32'h1 << ch);
            wr(at(OFS_TX_CP, ch), ptr ^ 32'h4);
            cycles(1);
            chk("tx_irq_kept", {31'h0, tx_chan_irq[ch]}, 32'h1);
            wr(at(OFS_TX_CP, ch), ptr);
            cycles(1);
            chk("tx_irq_clear", {24'h0, tx_chan_irq}, 32'h0);
            rd(at(OFS_TX_CP, ch), ptr, "tx_cp");
        end
    endtask : tx_done

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(OFS_INDEX, 32'h0, "index_reset");
        rd(OFS_MASK, 32'h0, "mask_reset");
        for (int n = 0; n < CHANNELS; n++) begin
            wr(at(OFS_TX_HEAD, n), 32'h0);
            wr(at(OFS_RX_HEAD, n), 32'h0);
        end
        chk("busy_armed", {16'h0, tx_busy, rx_armed}, 32'h0);
        rd(OFS_STATUS, 32'h0, "status_zero_heads");
        wr(OFS_INDEX, 32'hffffffe5);
        rd(OFS_INDEX, 32'h5, "index_field");
        wr(OFS_UPPER, 32'h22334455);
        rd(OFS_UPPER, 32'h22334455, "upper");
        for (int i = 0; i < RAM_DEPTH; i++) prog(5'(i), 32'h0, 32'h0);
        rd(OFS_INDEX, 32'h1f, "index_top");
        prog(5'd3, 32'h22334455, 32'h001d0011);
        prog(5'd7, 32'h22334455, 32'h00160011);
        prog(5'd9, 32'h22334455, 32'h000d0011);
        rd(OFS_LOWER, 32'h000d0011, "lower");
        rd(9'h080, 32'h0, "unmapped");
        look(5'd3, 48'h554433221100, 7'b1101010);
        look(5'd3, 48'h564433221100, 7'b1000000);
        look(5'd3, 48'h554433221101, 7'b1000000);
        look(5'd7, 48'h554433221100, 7'b1010000);
        look(5'd9, 48'h554433221100, 7'b1000000);
        look(5'd0, 48'h0, 7'b1000000);
        wr(OFS_INDEX, 32'h3);
        wr(OFS_UPPER, 32'haabbccdd);
        look(5'd3, 48'h554433221100, 7'b1101010);
        wr(OFS_LOWER, 32'h001d0011);
        look(5'd3, 48'hddccbbaa1100, 7'b1101010);
        look(5'd3, 48'h554433221100, 7'b1000000);
        wr(OFS_MASK, 32'hf);
        for (int ch = 0; ch < CHANNELS; ch++) begin
            wr(at(OFS_TX_HEAD, ch), 32'h1000 + 32'(ch * 16));
            chk("start_busy", {16'h0, tx_start, tx_busy}, {16'h0, {2{8'(1 << ch)}}});
            tx_done(ch, 32'h1000 + 32'(ch * 16));
            chk("irq_on", {31'h0, irq}, 32'h1);
            rd(OFS_STATUS, 32'h4, "status_tx_done");
            cycles(1);
            chk("irq_off", {31'h0, irq}, 32'h0);
            rd(OFS_STATUS, 32'h0, "status_cleared");
        end
        @(posedge clk_sys);
        hold <= 1'b1;
        wr(at(OFS_TX_HEAD, 2), 32'h2000);
        wr(at(OFS_TX_HEAD, 2), 32'h3000);
        rd(at(OFS_TX_HEAD, 2), 32'h2000, "tx_head_kept");
        rd(OFS_STATUS, 32'h1, "status_tx_err");
        wr(at(OFS_RX_HEAD, 4), 32'h5000);
        wr(at(OFS_RX_HEAD, 4), 32'h6000);
        chk("rx_armed", {24'h0, rx_armed}, 32'h10);
        rd(at(OFS_RX_HEAD, 4), 32'h5000, "rx_head_kept");
        rd(OFS_CHAN, 32'h00001004, "chan_status");
        rd(OFS_STATUS, 32'h2, "status_rx_err");
        @(posedge clk_sys);
        hold <= 1'b0;
        tx_done(2, 32'h2000);
        look(5'd3, 48'hddccbbaa1100, 7'b1101010);
        wr(at(OFS_RX_HEAD, 5), 32'h7000);
        look(5'd3, 48'hddccbbaa1100, 7'b1101011);
        cycles(3);
        chk("rx_irq", {24'h0, rx_chan_irq}, 32'h20);
        rd(OFS_STATUS, 32'hc, "status_rx_done");
        wr(at(OFS_RX_CP, 5), 32'h7000);
        cycles(1);
        chk("rx_irq_clear", {24'h0, rx_chan_irq}, 32'h0);
        wr(OFS_MASK, 32'h0);
        wr(at(OFS_TX_HEAD, 1), 32'h8000);
        tx_done(1, 32'h8000);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        rd(OFS_STATUS, 32'h4, "status_masked");
        close_out();
    end
endmodule : mac_address_ram_and_dma_pointers_tb
